// ### src/lsd_pkg.sv
// Constants shared by the delay control port and its register file
package lsd_pkg;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h01;
  localparam logic [7:0] OFS_RDLY_HIGH = 8'h02;
  localparam logic [7:0] OFS_RDLY_LOW = 8'h03;
  localparam logic [7:0] OFS_LDLY_HIGH = 8'h04;
  localparam logic [7:0] OFS_LDLY_LOW = 8'h05;
  localparam logic [7:0] OFS_FRAME = 8'h06;
  localparam logic [7:0] OFS_RJ_WIDTH = 8'h07;
  localparam logic [7:0] OFS_COMMIT = 8'h08;
  // Reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;
  // Target address: fixed upper nibble, pins give the rest
  localparam logic [3:0] ADDR_FIXED = 4'hD;
  // Control register fields
  localparam int MUTE_RIGHT_BIT = 7;
  localparam int MUTE_LEFT_BIT = 6;
  localparam int FMT_LSB = 0;
  localparam int FMT_W = 2;
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_RIGHT_JUST = 2'h1;
  localparam logic [1:0] FMT_LEFT_JUST = 2'h2;
  localparam logic [1:0] FMT_BYPASS = 2'h3;
  // Delay fields
  localparam int DLY_W = 13;
  localparam int DLY_HIGH_W = 5;
  localparam int DLY_LOW_W = 8;
  // Commit register trigger bit
  localparam int COMMIT_BIT = 0;
  // Bit count of one byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // Write buffer shape
  localparam int WBUF_WIDTH = 16;
  localparam int WBUF_DEPTH = 8;
endpackage

// ### src/lsd_fifo.sv
// Small first-in first-out buffer held in flip-flops
`timescale 1ns/1ps
module lsd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  // Handshakes
  assign in_ready = (count != CNT_FULL);
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ### src/lsd_i2c_regs.sv
// Two-wire control port and register file of the stereo delay
`timescale 1ns/1ps
module lsd_i2c_regs (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_high,
  input wire logic addr_select_mid,
  input wire logic addr_select_low,
  output logic mute_left,
  output logic mute_right,
  output logic [lsd_pkg::FMT_W-1:0] audio_format,
  output logic bypass,
  output logic [lsd_pkg::DLY_W-1:0] delay_right,
  output logic [lsd_pkg::DLY_W-1:0] delay_left,
  output logic [7:0] frame_delay_cfg,
  output logic [7:0] right_just_width,
  output logic settings_commit
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_ACK, ST_TX, ST_RACK
  } lsd_state_t;
  lsd_state_t state;
  lsd_state_t ack_next;
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] ptr;
  logic master_ack;
  logic [6:0] my_addr;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic byte_done;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;
  logic [lsd_pkg::WBUF_WIDTH-1:0] pop_data;
  logic [7:0] pop_addr;
  logic [7:0] pop_byte;
  logic pop;
  logic commit_hit;
  logic [7:0] rd_byte;
  // Register file
  logic [7:0] channel_mute_format;
  logic [lsd_pkg::DLY_HIGH_W-1:0] right_delay_high;
  logic [7:0] right_delay_low;
  logic [lsd_pkg::DLY_HIGH_W-1:0] left_delay_high;
  logic [7:0] left_delay_low;
  logic [7:0] video_frame_delay_cfg;
  logic [7:0] right_just_width_reg;
  logic [7:0] commit_settings;
  // Read mux over the register map; unmapped offsets read zero
  function automatic logic [7:0] read_reg(input logic [7:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    case (ofs)
      lsd_pkg::OFS_CTRL: v = channel_mute_format;
      lsd_pkg::OFS_RDLY_HIGH: v = 8'(right_delay_high);
      lsd_pkg::OFS_RDLY_LOW: v = right_delay_low;
      lsd_pkg::OFS_LDLY_HIGH: v = 8'(left_delay_high);
      lsd_pkg::OFS_LDLY_LOW: v = left_delay_low;
      lsd_pkg::OFS_FRAME: v = video_frame_delay_cfg;
      lsd_pkg::OFS_RJ_WIDTH: v = right_just_width_reg;
      lsd_pkg::OFS_COMMIT: v = commit_settings;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus sampling and condition detection
  // Own address from the fixed nibble and the select pins
  assign my_addr = {lsd_pkg::ADDR_FIXED, addr_select_high,
                    addr_select_mid, addr_select_low};
  // Previous levels of both lines
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end
  // Edges and bus conditions
  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign start_cond = scl && scl_q && sda_q && !sda_in;
  assign stop_cond = scl && scl_q && !sda_q && sda_in;
  assign byte_done = scl_fall && (bit_cnt == lsd_pkg::BYTE_BITS);
  assign sda_out = 1'b0; // Open drain: only ever pulls low
  assign rd_byte = read_reg(ptr);
  // Write bytes queue up with their target offset
  assign push_valid = (state == ST_WDATA) && byte_done;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer
  // Byte framing, acknowledge and read shifting
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      ack_next <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      ptr <= 8'h00;
      sda_oe <= 1'b0;
      master_ack <= 1'b0;
    end else if (start_cond) begin
      // Start or repeated start ends any transfer in progress
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (scl_rise && bit_cnt != lsd_pkg::BYTE_BITS) begin
            shift <= {shift[6:0], sda_in};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            bit_cnt <= 4'h0;
            state <= ST_ACK;
            if (state == ST_ADDR) begin
              if (shift[7:1] == my_addr) begin
                sda_oe <= 1'b1;
                ack_next <= shift[0] ? ST_TX : ST_REG;
              end else begin
                state <= ST_IDLE;
              end
            end else if (state == ST_REG) begin
              ptr <= shift;
              sda_oe <= 1'b1;
              ack_next <= ST_WDATA;
            end else if (push_ready) begin
              ptr <= ptr + 8'h01;
              sda_oe <= 1'b1;
              ack_next <= ST_WDATA;
            end else begin
              ack_next <= ST_IDLE; // Buffer full: byte refused by not-ack
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state <= ack_next;
            sda_oe <= 1'b0;
            if (ack_next == ST_TX) begin
              shift <= rd_byte;
              sda_oe <= !rd_byte[7];
              ptr <= ptr + 8'h01;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt == lsd_pkg::LAST_BIT) begin
              sda_oe <= 1'b0;
              bit_cnt <= 4'h0;
              state <= ST_RACK;
            end else begin
              shift <= {shift[6:0], 1'b0};
              sda_oe <= !shift[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            master_ack <= !sda_in;
          end else if (scl_fall) begin
            if (master_ack) begin
              shift <= rd_byte;
              sda_oe <= !rd_byte[7];
              ptr <= ptr + 8'h01;
              state <= ST_TX;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write buffer between the wire and the register file
  // Draining pauses while a read is on the wire
  assign pop_ready = (state != ST_TX) && (state != ST_RACK);
  lsd_fifo #(
    .WIDTH(lsd_pkg::WBUF_WIDTH),
    .DEPTH(lsd_pkg::WBUF_DEPTH)
  ) u_wbuf (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data({ptr, shift}),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );
  assign pop = pop_valid && pop_ready;
  assign pop_addr = pop_data[15:8];
  assign pop_byte = pop_data[7:0];
  assign commit_hit = pop && (pop_addr == lsd_pkg::OFS_COMMIT) &&
                      pop_byte[lsd_pkg::COMMIT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  // Stores drained write bytes by offset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      channel_mute_format <= lsd_pkg::REG_RESET;
      right_delay_high <= '0;
      right_delay_low <= lsd_pkg::REG_RESET;
      left_delay_high <= '0;
      left_delay_low <= lsd_pkg::REG_RESET;
      video_frame_delay_cfg <= lsd_pkg::REG_RESET;
      right_just_width_reg <= lsd_pkg::REG_RESET;
      commit_settings <= lsd_pkg::REG_RESET;
    end else if (pop) begin
      case (pop_addr)
        lsd_pkg::OFS_CTRL: channel_mute_format <= pop_byte;
        lsd_pkg::OFS_RDLY_HIGH:
          right_delay_high <= pop_byte[lsd_pkg::DLY_HIGH_W-1:0];
        lsd_pkg::OFS_RDLY_LOW: right_delay_low <= pop_byte;
        lsd_pkg::OFS_LDLY_HIGH:
          left_delay_high <= pop_byte[lsd_pkg::DLY_HIGH_W-1:0];
        lsd_pkg::OFS_LDLY_LOW: left_delay_low <= pop_byte;
        lsd_pkg::OFS_FRAME: video_frame_delay_cfg <= pop_byte;
        lsd_pkg::OFS_RJ_WIDTH: right_just_width_reg <= pop_byte;
        lsd_pkg::OFS_COMMIT: commit_settings <= pop_byte;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings seen by the delay path
  // Mute follows the control register at once
  assign mute_left = channel_mute_format[lsd_pkg::MUTE_LEFT_BIT];
  assign mute_right = channel_mute_format[lsd_pkg::MUTE_RIGHT_BIT];
  // Pending settings move across only on a commit
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      audio_format <= lsd_pkg::FMT_I2S;
      bypass <= 1'b0;
      delay_right <= '0;
      delay_left <= '0;
      frame_delay_cfg <= lsd_pkg::REG_RESET;
      right_just_width <= lsd_pkg::REG_RESET;
    end else if (commit_hit) begin
      audio_format <=
        channel_mute_format[lsd_pkg::FMT_LSB +: lsd_pkg::FMT_W];
      bypass <= (channel_mute_format[lsd_pkg::FMT_LSB +: lsd_pkg::FMT_W]
                 == lsd_pkg::FMT_BYPASS);
      if (channel_mute_format[lsd_pkg::FMT_LSB +: lsd_pkg::FMT_W]
          == lsd_pkg::FMT_BYPASS) begin
        delay_right <= '0;
        delay_left <= '0;
      end else begin
        delay_right <= {right_delay_high, right_delay_low};
        delay_left <= {left_delay_high, left_delay_low};
      end
      frame_delay_cfg <= video_frame_delay_cfg;
      right_just_width <= right_just_width_reg;
    end
  end
  // One-cycle mark of each commit
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      settings_commit <= 1'b0;
    end else begin
      settings_commit <= commit_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_addr_write_match;
    state == ST_ADDR && byte_done && shift[7:1] == my_addr && !shift[0];
  endsequence
  sequence s_read_ack_taken;
    state == ST_RACK && scl_fall && master_ack;
  endsequence
  a_addr_write_ack: assert property (
    s_addr_write_match |=> sda_oe && state == ST_ACK && ack_next == ST_REG)
    else $error("address write not acknowledged");
  a_addr_other_ignored: assert property (
    state == ST_ADDR && byte_done && shift[7:1] != my_addr |=> !sda_oe)
    else $error("foreign address acknowledged");
  a_reg_select_ack: assert property (
    state == ST_REG && byte_done && !start_cond && !stop_cond
    |=> sda_oe && ptr == $past(shift))
    else $error("register byte not taken");
  a_data_ack_step: assert property (
    push_valid && push_ready && !start_cond && !stop_cond
    |=> sda_oe && ptr == $past(ptr) + 8'h01)
    else $error("data byte not acknowledged");
  a_read_next_byte: assert property (
    (s_read_ack_taken and (!start_cond && !stop_cond))
    |=> state == ST_TX && shift == $past(rd_byte))
    else $error("next read byte not loaded");
  a_nack_releases: assert property (
    state == ST_RACK && scl_fall && !master_ack && !start_cond
    |=> state == ST_IDLE ##1 !sda_oe)
    else $error("line held after not-ack");
  a_mute_direct: assert property (
    pop && pop_addr == lsd_pkg::OFS_CTRL
    |=> mute_left == $past(pop_byte[lsd_pkg::MUTE_LEFT_BIT])
        && mute_right == $past(pop_byte[lsd_pkg::MUTE_RIGHT_BIT]))
    else $error("mute did not follow control write");
  a_commit_gate: assert property (
    !commit_hit |=> $stable(audio_format) && $stable(delay_right)
                    && $stable(delay_left))
    else $error("settings moved without commit");
  a_bypass_nodelay: assert property (
    bypass |-> delay_right == '0 && delay_left == '0
               && audio_format == lsd_pkg::FMT_BYPASS)
    else $error("bypass with delay");
  a_delay_join: assert property (
    commit_hit && channel_mute_format[lsd_pkg::FMT_LSB +: lsd_pkg::FMT_W]
    != lsd_pkg::FMT_BYPASS
    |=> delay_right == {$past(right_delay_high), $past(right_delay_low)}
        && delay_left == {$past(left_delay_high), $past(left_delay_low)}
        && settings_commit)
    else $error("delay not assembled from halves");
endmodule

// ### testbench/lsd_i2c_master.sv
// Behavioural two-wire bus master facing the delay control port
`timescale 1ns/1ps
module lsd_i2c_master (
  input wire logic clk_sys,
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output logic sda_line
);
  logic sda_m;
  // Wired-AND of both parties; pull-up gives 1 when released
  assign sda_line = sda_m & ~(sda_oe & ~sda_out);
  // Bus idle from time zero
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // One bit: data changes in scl low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_m = b;
    tick(4);
    scl = 1'b1;
    tick(3);
    r = sda_line;
    tick(3);
    scl = 1'b0;
  endtask
  // Start or repeated start: data falls while scl high
  task automatic start_cond();
    tick(2);
    sda_m = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask
  // Stop: data rises while scl high
  task automatic stop_cond();
    tick(2);
    sda_m = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b1;
    tick(6);
  endtask
  // Byte out, most significant bit first, then sample acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Byte in, then acknowledge or not-acknowledge
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, r);
  endtask
  // Register write of n bytes taken from the top of d
  task automatic wr(input logic [6:0] dev, input logic [7:0] ofs,
    input logic [63:0] d, input int n, output logic ok);
    logic a;
    start_cond();
    send_byte({dev, 1'b0}, a);
    ok = a;
    if (a) begin
      send_byte(ofs, a);
      ok = ok & a;
      for (int i = 0; i < n; i++) begin
        send_byte(d[63-8*i -: 8], a);
        ok = ok & a;
      end
    end
    stop_cond();
  endtask
  // Register read of n bytes placed at the top of q
  task automatic rd(input logic [6:0] dev, input logic [7:0] ofs,
    input int n, output logic [63:0] q, output logic ok);
    logic a;
    logic [7:0] b;
    q = 64'h0000_0000_0000_0000;
    start_cond();
    send_byte({dev, 1'b0}, a);
    ok = a;
    send_byte(ofs, a);
    ok = ok & a;
    start_cond();
    send_byte({dev, 1'b1}, a);
    ok = ok & a;
    for (int i = 0; i < n; i++) begin
      recv_byte(i < n - 1, b);
      q[63-8*i -: 8] = b;
    end
    stop_cond();
  endtask
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the delay control port and its buffer
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, reset_n, scl, sda_line, sda_out, sda_oe;
  logic [2:0] pins;
  logic mute_left, mute_right, bypass, settings_commit, ok;
  logic [1:0] audio_format;
  logic [12:0] delay_right, delay_left;
  logic [7:0] frame_delay_cfg, right_just_width;
  logic [6:0] dev;
  logic [63:0] q;
  int fail_count, n_tests, commit_cnt;
  lsd_i2c_regs u_lsd_i2c_regs (.clk_sys(clk_sys), .reset_n(reset_n),
    .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_select_high(pins[2]), .addr_select_mid(pins[1]),
    .addr_select_low(pins[0]), .mute_left(mute_left),
    .mute_right(mute_right), .audio_format(audio_format),
    .bypass(bypass), .delay_right(delay_right), .delay_left(delay_left),
    .frame_delay_cfg(frame_delay_cfg), .right_just_width(right_just_width),
    .settings_commit(settings_commit));
  lsd_i2c_master u_lsd_i2c_master (.clk_sys(clk_sys), .sda_oe(sda_oe),
    .sda_out(sda_out), .scl(scl), .sda_line(sda_line));
  // Free-running system clock, 8 ns period
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Counts commit pulses, sampled where they are settled
  always @(negedge clk_sys) if (settings_commit === 1'b1) commit_cnt++;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
    input string what);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
        exp);
      fail_count++;
    end
  endtask
  task automatic results();
    $display("tests %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [63:0] d,
    input int n);
    u_lsd_i2c_master.wr(dev, ofs, d, n, ok);
    chk(ok, 1'b1, "write acknowledge");
  endtask
  task automatic commit(input logic [7:0] v);
    wr(lsd_pkg::OFS_COMMIT, {v, 56'h0}, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({sda_oe, mute_left, mute_right, audio_format, bypass}, 0, "rst");
    chk({delay_right, delay_left, frame_delay_cfg}, 0, "rst delays");
    u_lsd_i2c_master.rd(dev, lsd_pkg::OFS_CTRL, 8, q, ok);
    chk(ok, 1'b1, "read ack");
    chk(q, 64'h0000_0000_0000_0000, "reset values");
  endtask
  task automatic t_mute();
    for (int m = 0; m < 4; m++) begin
      wr(lsd_pkg::OFS_CTRL, {m[1:0], 62'h0}, 1);
      chk({mute_right, mute_left}, m[1:0], "mute pattern");
    end
    chk(commit_cnt, 0, "no commit from mute");
  endtask
  task automatic t_delay();
    wr(lsd_pkg::OFS_CTRL, 64'h01FF_FF10_0000_0000, 5);
    chk({audio_format, delay_right, delay_left}, 0, "pending");
    commit(8'h01);
    chk(commit_cnt, 1, "commit pulse");
    chk(audio_format, lsd_pkg::FMT_RIGHT_JUST, "format rj");
    chk(delay_right, 13'h1FFF, "right max");
    chk(delay_left, 13'h1000, "left delay");
    u_lsd_i2c_master.rd(dev, lsd_pkg::OFS_RDLY_HIGH, 1, q, ok);
    chk(q[63:56], 8'h1F, "high bits read zero");
  endtask
  task automatic t_format();
    for (int f = 3; f >= 0; f--) begin
      wr(lsd_pkg::OFS_CTRL, {6'h00, f[1:0], 56'h0}, 1);
      commit(8'h01);
      chk(audio_format, f[1:0], "format");
      chk(bypass, f == 3, "bypass");
      chk(delay_right, (f == 3) ? 0 : 13'h1FFF, "bypass delay");
    end
  endtask
  task automatic t_zero();
    wr(lsd_pkg::OFS_CTRL, 64'h0000_0000_00A5_1800, 7);
    commit(8'hFE);
    chk(delay_right, 13'h1FFF, "bit0 clear no apply");
    chk(frame_delay_cfg, 8'h00, "frame pending");
    commit(8'h01);
    chk({delay_right, delay_left}, 0, "zero delay");
    chk({frame_delay_cfg, right_just_width}, 16'hA518, "frame rj");
  endtask
  task automatic t_addr();
    for (int p = 0; p < 8; p++) begin
      pins = p[2:0];
      u_lsd_i2c_master.wr({4'hD, p[2:0]}, lsd_pkg::OFS_CTRL, 0, 0, ok);
      chk(ok, 1'b1, "own address");
      u_lsd_i2c_master.wr({4'hD, ~p[2:0]}, lsd_pkg::OFS_CTRL, 0, 0, ok);
      chk(ok, 1'b0, "pin mismatch");
      u_lsd_i2c_master.wr({4'hC, p[2:0]}, lsd_pkg::OFS_CTRL, 0, 0, ok);
      chk(ok, 1'b0, "fixed mismatch");
    end
    pins = 3'h1;
  endtask
  task automatic t_read();
    wr(lsd_pkg::OFS_RDLY_HIGH, 64'h0344_0566_7700_0000, 5);
    u_lsd_i2c_master.rd(dev, lsd_pkg::OFS_CTRL, 8, q, ok);
    chk(q, 64'h0003_4405_6677_1801, "multi read");
    chk(sda_oe, 1'b0, "line released");
    u_lsd_i2c_master.rd(dev, lsd_pkg::OFS_LDLY_LOW, 1, q, ok);
    chk(q[63:56], 8'h66, "single read");
    u_lsd_i2c_master.rd(dev, 8'h00, 1, q, ok);
    chk(q[63:56], 8'h00, "unmapped read");
  endtask
  task automatic t_fifo();
    // Eight bytes queue in one burst; the last one commits the rest
    wr(lsd_pkg::OFS_CTRL, 64'h4201_00C8_0123_7F01, 8);
    chk({mute_right, mute_left}, 2'h1, "burst mute");
    chk(audio_format, lsd_pkg::FMT_LEFT_JUST, "burst format");
    chk(delay_right, 13'h0100, "burst right");
    chk(delay_left, 13'h0801, "burst left");
    chk({frame_delay_cfg, right_just_width}, 16'h237F, "burst rest");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watchdog cuts a hang well past the expected run
  initial begin
    #400_000;
    fail_count++;
    results();
  end
  // Main sequence
  initial begin
    fail_count = 0;
    n_tests = 0;
    commit_cnt = 0;
    reset_n = 1'b0;
    pins = 3'h1;
    dev = {lsd_pkg::ADDR_FIXED, 3'h1};
    repeat (5) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_reset();
    t_mute();
    t_delay();
    t_format();
    t_zero();
    t_addr();
    t_read();
    t_fifo();
    results();
  end
endmodule
